// file: include/opmac_consts.svh
// Constants for the programmable output macrocell block
`ifndef OPMAC_CONSTS_SVH
`define OPMAC_CONSTS_SVH

`define OPMAC_CLK_NS 40
`define OPMAC_PWRUP_NS 1000
`define OPMAC_PWRUP_CYC (`OPMAC_PWRUP_NS / `OPMAC_CLK_NS)
`define OPMAC_IDLE_NS 50
`define OPMAC_IDLE_CYC ((`OPMAC_IDLE_NS + `OPMAC_CLK_NS - 1) / `OPMAC_CLK_NS)
`define OPMAC_ADR_CFG 4'h0
`define OPMAC_ADR_OEN 4'h1
`define OPMAC_ADR_CTL 4'h2
`define OPMAC_ADR_STAT 4'h3
`define OPMAC_ADR_PLD 4'h4
`define OPMAC_ADR_PIN 4'h5
`define OPMAC_ADR_TERM 4'h6
`define OPMAC_ADR_USED 4'h7
`define OPMAC_CTL_PRELOAD 0
`define OPMAC_CTL_SECURE 1
`define OPMAC_CTL_ERASE 2
`define OPMAC_CTL_LOWPWR 3
`define OPMAC_CFG_RST 32'h0000_0000
`define OPMAC_OEN_RST 32'h0000_0000
`define OPMAC_USED_RST 32'h0000_0000

`endif

// file: include/opmac_pkg.sv
// Types for the programmable output macrocell block
package opmac_pkg;
	typedef enum logic [1:0] {
		OPMAC_PWRUP,
		OPMAC_RUN,
		OPMAC_STANDBY
	} opmac_state_t;
endpackage

// file: tb/opmac_board.sv
// Board model driving the macrocell pins
module opmac_board #(parameter int CELLS = 10) (
	input wire logic clk_in,
	input wire logic [CELLS-1:0] drv_in,
	input wire logic [CELLS-1:0] oe_in,
	input wire logic [CELLS-1:0] ext_in,
	input wire logic [CELLS-1:0] ext_en_in,
	output logic [CELLS-1:0] pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [CELLS-1:0] float_r;
	// A released pin shows the inverse of the last driven value
	always_ff @(posedge clk_in) float_r <= ~drv_in;
	// Device drives when enabled, else the board, else the floating level
	assign pin_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
		| (~oe_in & ~ext_en_in & float_r);
endmodule // opmac_board

// file: tb/opmac_chk.sv
// Concurrent checks on the macrocell top ports
module opmac_chk #(parameter int CELLS = 10) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [CELLS-1:0] sum_in,
	input wire logic [CELLS-1:0] oe_term_in,
	input wire logic [CELLS-1:0] pin_out,
	input wire logic [CELLS-1:0] pin_oe_out,
	input wire logic standby_out,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	wire req = wb_cyc_i & wb_stb_i;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_ack_follows: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_cause: assert property (wb_ack_o |-> $past(req))
		else $error("ack without request");
	a_dat_hold: assert property (!req |=> $stable(wb_dat_o))
		else $error("read data moved while idle");
	a_reset_quiet: assert property (disable iff (1'b0) !nrst_in |=> pin_out == '0
		&& pin_oe_out == '0 && !wb_ack_o) else $error("outputs active in reset");
	a_oe_term: assert property (!standby_out && !$past(standby_out) |->
		(pin_oe_out & ~$past(oe_term_in)) == '0) else $error("enable without term");
	a_standby_freeze: assert property (standby_out && $past(standby_out) |->
		$stable(pin_out) && $stable(pin_oe_out)) else $error("outputs moved in standby");
	a_standby_exit: assert property ($changed(sum_in) |-> ##[1:4] !standby_out)
		else $error("standby kept after toggle");
	a_standby_idle: assert property ($rose(standby_out) |->
		$past(sum_in) == $past(sum_in, 2)) else $error("standby while inputs toggle");
	c_standby: cover property ($rose(standby_out));
	c_wake: cover property ($fell(standby_out));
	c_drive: cover property (|pin_oe_out);
endmodule // opmac_chk
bind opmac_top opmac_chk #(.CELLS(CELLS)) u_chk (.ref_clk_in, .nrst_in, .sum_in, .oe_term_in,
	.pin_out, .pin_oe_out, .standby_out, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);

// file: tb/tb_programmable_output_macrocell.sv
// Self-checking bench for the output macrocell block
`include "opmac_consts.svh"
module tb_programmable_output_macrocell;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_in, nrst_in, spre, arst, stby, cyc, we, ack;
	logic [9:0] sum, oe, pin_lvl, pout, poe, fb, ext, ext_en, pol;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, rd;
	int n_errors = 0, samples_checked = 0, seed;
	opmac_top #(.CELLS(10), .PWRUP_CYC(2), .IDLE_CYC(2)) dut (.ref_clk_in, .nrst_in,
		.sum_in(sum), .oe_term_in(oe), .sync_preset_term_in(spre),
		.async_reset_term_in(arst), .pin_in(pin_lvl), .pin_out(pout), .pin_oe_out(poe),
		.feedback_out(fb), .standby_out(stby), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	opmac_board #(.CELLS(10)) board (.clk_in(ref_clk_in), .drv_in(pout), .oe_in(poe),
		.ext_in(ext), .ext_en_in(ext_en), .pin_out(pin_lvl));
	function automatic logic [9:0] pexp(input logic [9:0] q, input logic [9:0] p);
		return q ^ ~p;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		{cyc, we, adr, wdat} <= {1'b1, w, a, d};
		do begin
			@(posedge ref_clk_in);
		end while (ack !== 1'b1);
		chk("ack", 1, ack);
		rd = rdat;
		cyc <= 1'b0;
	endtask
	task settle();
		repeat (8) @(posedge ref_clk_in);
	endtask
	task end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		n_errors++;
		end_of_test();
	end
	initial begin
		seed = 32'h537B2427;
		{nrst_in, cyc, we, spre, arst, adr, wdat, sum, oe, ext, ext_en} = '0;
		repeat (4) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		settle();
		wb(0, `OPMAC_ADR_TERM, 0);
		chk("q_pwrup", 0, rd);
		wb(1, `OPMAC_ADR_OEN, 0);
		for (int i = 0; i < 12; i++) begin
			pol = 10'($random(seed));
			wb(1, `OPMAC_ADR_CFG, {22'h0, pol});
			sum <= 10'($random(seed));
			oe <= (i == 0) ? 10'h3FF : 10'($random(seed));
			settle();
			wb(0, `OPMAC_ADR_TERM, 0);
			chk("q_reg", sum, rd);
			chk("pin_reg", pexp(sum, pol), pout);
			chk("oe", oe, poe);
			chk("fb_reg", 10'(~sum), fb);
		end
		sum <= '0;
		spre <= 1'b1;
		settle();
		wb(0, `OPMAC_ADR_TERM, 0);
		chk("q_preset", 10'h3FF, rd);
		chk("pin_preset", pexp(10'h3FF, pol), pout);
		{spre, arst, sum} <= {2'b01, 10'h3FF};
		settle();
		wb(0, `OPMAC_ADR_TERM, 0);
		chk("q_clear", 0, rd);
		chk("pin_clear", pexp(0, pol), pout);
		arst <= 1'b0;
		pol = 10'($random(seed));
		wb(1, `OPMAC_ADR_CFG, {6'h0, 10'h3FF, 6'h0, pol});
		{oe, ext_en, ext, sum} <= {10'h0, 10'h3FF, 10'($random(seed)), 10'($random(seed))};
		settle();
		chk("pin_comb", pexp(sum, pol), pout);
		chk("fb_pin", ext, fb);
		wb(1, `OPMAC_ADR_CFG, 0);
		wb(1, `OPMAC_ADR_CTL, 32'h1);
		settle();
		wb(0, `OPMAC_ADR_TERM, 0);
		chk("q_preload", ext, rd);
		wb(1, `OPMAC_ADR_CTL, 32'h3);
		sum <= ~ext;
		settle();
		wb(0, `OPMAC_ADR_TERM, 0);
		chk("q_secure", 10'(~ext), rd);
		wb(1, `OPMAC_ADR_CFG, 0);
		wb(0, `OPMAC_ADR_CFG, 0);
		chk("cfg_secure", 32'hFFFFFFFF, rd);
		wb(1, `OPMAC_ADR_CTL, 32'h0);
		wb(0, `OPMAC_ADR_CFG, 0);
		chk("cfg_kept", 32'hFFFFFFFF, rd);
		wb(1, `OPMAC_ADR_CTL, 32'h4);
		wb(0, `OPMAC_ADR_CFG, 0);
		chk("cfg_erased", 32'h03FF03FF, rd);
		wb(0, 4'hF, 0);
		chk("unmapped", 0, rd);
		wb(1, `OPMAC_ADR_USED, 32'h0000_03FF);
		wb(1, `OPMAC_ADR_CTL, 32'h8);
		repeat (12) @(posedge ref_clk_in);
		chk("standby", 1, stby);
		chk("pin_hold", sum, pout);
		sum <= ext;
		repeat (4) @(posedge ref_clk_in);
		chk("wake", 0, stby);
		chk("pin_wake", ext, pout);
		end_of_test();
	end
endmodule // tb_programmable_output_macrocell

// file: verilog/opmac_cell.sv
// One output macrocell: register, bypass, polarity, three-state buffer
`include "opmac_consts.svh"
module opmac_cell (
	input wire logic ref_clk_in,
	input wire logic run_in,
	input wire logic sum_in,
	input wire logic oe_term_in,
	input wire logic bypass_in,
	input wire logic polarity_in,
	input wire logic sync_preset_term_in,
	input wire logic async_reset_term_in,
	input wire logic clear_in,
	input wire logic preload_in,
	input wire logic preload_val_in,
	input wire logic pin_level_in,
	output logic q_out,
	output logic pin_val_out,
	output logic pin_oe_out,
	output logic feedback_out
);
	logic q_r;
	wire logic stage_w;

	// Async clear has priority, then power-up clear, preload, preset and capture
	always_ff @(posedge ref_clk_in or posedge async_reset_term_in) begin
		if (async_reset_term_in) begin
			q_r <= 1'b0;
		end else if (clear_in) begin
			q_r <= 1'b0;
		end else if (preload_in) begin
			q_r <= preload_val_in;
		end else if (run_in && sync_preset_term_in) begin
			q_r <= 1'b1;
		end else if (run_in) begin
			q_r <= sum_in;
		end
	end

	assign stage_w = bypass_in ? sum_in : q_r;
	assign q_out = q_r;
	assign pin_val_out = polarity_in ? stage_w : ~stage_w;
	assign pin_oe_out = oe_term_in;
	assign feedback_out = bypass_in ? pin_level_in : ~q_r;
endmodule // opmac_cell

// file: verilog/opmac_top.sv
// Output macrocell array with Wishbone control registers
//
// Local design decisions: register access over Wishbone and the register addresses.
`include "opmac_consts.svh"
module opmac_top #(
	parameter int CELLS = 10,
	parameter int PWRUP_CYC = `OPMAC_PWRUP_CYC,
	parameter int IDLE_CYC = `OPMAC_IDLE_CYC
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic [CELLS-1:0] sum_in,
	input wire logic [CELLS-1:0] oe_term_in,
	input wire logic sync_preset_term_in,
	input wire logic async_reset_term_in,
	input wire logic [CELLS-1:0] pin_in,
	output logic [CELLS-1:0] pin_out,
	output logic [CELLS-1:0] pin_oe_out,
	output logic [CELLS-1:0] feedback_out,
	output logic standby_out,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// Counter widths limit the timing counts
	if (CELLS < 1 || CELLS > 16) begin : g_bad_cells
		$error("CELLS must be 1..16");
	end
	if (PWRUP_CYC < 1 || PWRUP_CYC > 1024 || IDLE_CYC < 1 || IDLE_CYC > 255) begin : g_bad_cnt
		$error("counts out of range");
	end

	opmac_pkg::opmac_state_t state_r, state_nxt;
	logic [CELLS-1:0] bypass_r, polarity_r, oen_mask_r, used_r, pld_val_r;
	logic secure_r, preload_r, lowpwr_r;
	logic [9:0] pwr_cnt_r;
	logic [7:0] idle_cnt_r;
	logic [CELLS-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
	logic sp_f_r;
	logic [CELLS-1:0] pin_val_w, oe_w, fb_w, q_w;
	logic [CELLS-1:0] pin_r, oe_r, fb_r;
	logic [2*CELLS+1:0] in_d_r;
	logic sp_s1_r, sp_s2_r, sp_s3_r;
	logic standby_r, ack_r;
	logic [31:0] rdat_r;

	wire logic req_w = wb_cyc_i && wb_stb_i && !ack_r;
	wire logic wr_w = req_w && wb_we_i && wb_sel_i[0];
	wire logic wr_cfg_w = wr_w && (wb_adr_i == `OPMAC_ADR_CFG);
	wire logic wr_oen_w = wr_w && (wb_adr_i == `OPMAC_ADR_OEN);
	wire logic wr_ctl_w = wr_w && (wb_adr_i == `OPMAC_ADR_CTL);
	wire logic wr_pld_w = wr_w && (wb_adr_i == `OPMAC_ADR_PLD);
	wire logic wr_used_w = wr_w && (wb_adr_i == `OPMAC_ADR_USED);
	wire logic erase_w = wr_ctl_w && wb_dat_i[`OPMAC_CTL_ERASE];
	wire logic run_w = (state_r == opmac_pkg::OPMAC_RUN);
	wire logic clear_w = (state_r == opmac_pkg::OPMAC_PWRUP);
	// Preload takes the pin levels, blocked once secured
	wire logic preload_w = preload_r && !secure_r && !clear_w;
	// Every term input counts as activity for standby; pin_in does not
	wire logic [2*CELLS+1:0] in_now_w = {async_reset_term_in, sync_preset_term_in, oe_term_in,
		sum_in};
	wire logic toggle_w = (in_now_w != in_d_r);
	wire logic idle_done_w = (idle_cnt_r >= 8'(IDLE_CYC));
	// In low-power mode unused terms drop to zero: enable off, sum off
	wire logic [CELLS-1:0] sum_use_w = lowpwr_r ? (sum_in & used_r) : sum_in;
	wire logic [CELLS-1:0] oe_use_w = (lowpwr_r ? (oe_term_in & used_r) : oe_term_in)
		& ~oen_mask_r;
	// Secured readback shows all ones
	wire logic [31:0] cfg_rd_w = secure_r ? 32'hFFFF_FFFF
		: {16'(bypass_r), 16'(polarity_r)};

	genvar g;
	generate
		for (g = 0; g < CELLS; g++) begin : g_cell
			opmac_cell u_cell (
				.ref_clk_in(ref_clk_in),
				.run_in(run_w),
				.sum_in(sum_use_w[g]),
				.oe_term_in(oe_use_w[g]),
				.bypass_in(bypass_r[g]),
				.polarity_in(polarity_r[g]),
				.sync_preset_term_in(sp_f_r),
				.async_reset_term_in(async_reset_term_in),
				.clear_in(clear_w),
				.preload_in(preload_w),
				.preload_val_in(pin_f_r[g]),
				.pin_level_in(pin_f_r[g]),
				.q_out(q_w[g]),
				.pin_val_out(pin_val_w[g]),
				.pin_oe_out(oe_w[g]),
				.feedback_out(fb_w[g])
			);
		end
	endgenerate

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			opmac_pkg::OPMAC_PWRUP: begin
				if (pwr_cnt_r >= 10'(PWRUP_CYC - 1)) state_nxt = opmac_pkg::OPMAC_RUN;
			end
			opmac_pkg::OPMAC_RUN: begin
				if (lowpwr_r && idle_done_w && !toggle_w) begin
					state_nxt = opmac_pkg::OPMAC_STANDBY;
				end
			end
			opmac_pkg::OPMAC_STANDBY: begin
				if (toggle_w || !lowpwr_r) state_nxt = opmac_pkg::OPMAC_RUN;
			end
			default: state_nxt = opmac_pkg::OPMAC_PWRUP;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			state_r <= opmac_pkg::OPMAC_PWRUP;
			pwr_cnt_r <= 10'h000;
			idle_cnt_r <= 8'h00;
			in_d_r <= '0;
		end else begin
			state_r <= state_nxt;
			pwr_cnt_r <= clear_w ? pwr_cnt_r + 10'h001 : 10'h000;
			idle_cnt_r <= toggle_w ? 8'h00 : (idle_done_w ? idle_cnt_r : idle_cnt_r + 8'h01);
			in_d_r <= in_now_w;
		end
	end

	// Pin and preset term synchronisers
	always_ff @(posedge ref_clk_in) begin
		pin_s1_r <= pin_in;
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
		sp_s1_r <= sync_preset_term_in;
		sp_s2_r <= sp_s1_r;
		sp_s3_r <= sp_s2_r;
		if (pin_s2_r == pin_s3_r) pin_f_r <= pin_s3_r;
		if (sp_s2_r == sp_s3_r) sp_f_r <= sp_s3_r;
	end

	// Outputs frozen in standby
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			pin_r <= '0;
			oe_r <= '0;
			fb_r <= '0;
			standby_r <= 1'b0;
		end else begin
			standby_r <= (state_nxt == opmac_pkg::OPMAC_STANDBY);
			if (state_r != opmac_pkg::OPMAC_STANDBY) begin
				pin_r <= pin_val_w;
				oe_r <= oe_w;
				fb_r <= fb_w;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			bypass_r <= CELLS'(`OPMAC_CFG_RST);
			polarity_r <= CELLS'(`OPMAC_CFG_RST);
			oen_mask_r <= CELLS'(`OPMAC_OEN_RST);
			used_r <= CELLS'(`OPMAC_USED_RST);
			pld_val_r <= '0;
			secure_r <= 1'b0;
			preload_r <= 1'b0;
			lowpwr_r <= 1'b0;
		end else begin
			if (wr_cfg_w && !secure_r) begin
				polarity_r <= wb_dat_i[CELLS-1:0];
				bypass_r <= wb_dat_i[16+CELLS-1:16];
			end
			if (wr_oen_w) oen_mask_r <= wb_dat_i[CELLS-1:0];
			if (wr_used_w && !secure_r) used_r <= wb_dat_i[CELLS-1:0];
			if (wr_pld_w) pld_val_r <= wb_dat_i[CELLS-1:0];
			if (wr_ctl_w) begin
				preload_r <= wb_dat_i[`OPMAC_CTL_PRELOAD];
				lowpwr_r <= wb_dat_i[`OPMAC_CTL_LOWPWR];
			end
			if (erase_w) begin
				secure_r <= 1'b0;
				polarity_r <= '1;
				bypass_r <= '1;
				used_r <= '0;
			end else if (wr_ctl_w && wb_dat_i[`OPMAC_CTL_SECURE]) begin
				secure_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req_w;
			// Read data holds until the next request
			if (!req_w) rdat_r <= rdat_r;
			else if (wb_adr_i == `OPMAC_ADR_CFG) rdat_r <= cfg_rd_w;
			else if (wb_adr_i == `OPMAC_ADR_OEN) rdat_r <= 32'(oen_mask_r);
			else if (wb_adr_i == `OPMAC_ADR_CTL) begin
				rdat_r <= {28'h0000000, lowpwr_r, 1'b0, secure_r, preload_r};
			end
			else if (wb_adr_i == `OPMAC_ADR_STAT) begin
				rdat_r <= {30'h00000000, standby_r, clear_w};
			end
			else if (wb_adr_i == `OPMAC_ADR_PLD) rdat_r <= 32'(pld_val_r);
			else if (wb_adr_i == `OPMAC_ADR_PIN) rdat_r <= 32'(pin_f_r);
			else if (wb_adr_i == `OPMAC_ADR_TERM) rdat_r <= 32'(q_w);
			else if (wb_adr_i == `OPMAC_ADR_USED) rdat_r <= secure_r ? 32'hFFFF_FFFF : 32'(used_r);
			else rdat_r <= 32'h0000_0000;
		end
	end

	assign pin_out = pin_r;
	assign pin_oe_out = oe_r;
	assign feedback_out = fb_r;
	assign standby_out = standby_r;
	assign wb_dat_o = rdat_r;
	assign wb_ack_o = ack_r;
endmodule // opmac_top
